/* File: src/csic_pkg.sv */
// package: register map, field layout and types for the card status irq block
package csic_pkg;
    // register byte addresses on apb
    localparam logic [7:0] CSIC_CFG_ADDR    = 8'h00; // routing and enables
    localparam logic [7:0] CSIC_STAT_ADDR   = 8'h04; // sticky status, write one to clear
    localparam logic [7:0] CSIC_MASK_ADDR   = 8'h08; // interrupt mask, one passes
    localparam logic [7:0] CSIC_CTRL_ADDR   = 8'h0C; // socket mode and removal reset enable
    localparam logic [7:0] CSIC_PINS_ADDR   = 8'h10; // live pin levels, read only
    // field positions of the configuration register
    localparam int CSIC_ROUTE_LSB  = 4;
    localparam int CSIC_DET_BIT    = 3;
    localparam int CSIC_RDY_BIT    = 2;
    localparam int CSIC_WARN_BIT   = 1;
    localparam int CSIC_DEAD_BIT   = 0;
    // control register bits
    localparam int CSIC_IOMODE_BIT = 0;
    localparam int CSIC_RRST_BIT   = 1;
    // reset values
    localparam logic [7:0] CSIC_CFG_RST  = 8'h00;
    localparam logic [3:0] CSIC_STAT_RST = 4'h0;
    localparam logic [3:0] CSIC_MASK_RST = 4'h0;
    localparam logic [1:0] CSIC_CTRL_RST = 2'h0;
    // routing codes
    localparam logic [3:0] CSIC_ROUTE_IRQ3  = 4'h3;
    localparam logic [3:0] CSIC_ROUTE_IRQ4  = 4'h4;
    localparam logic [3:0] CSIC_ROUTE_IRQ5  = 4'h5;
    localparam logic [3:0] CSIC_ROUTE_IRQ7  = 4'h7;
    localparam logic [3:0] CSIC_ROUTE_IRQ9  = 4'h9;
    localparam logic [3:0] CSIC_ROUTE_IRQ10 = 4'hA;
    localparam int CSIC_NUM_EVENTS = 4;

    // card status pins as one bundle (all active low on the socket)
    typedef struct packed {
        logic card_detect_a_n;
        logic card_detect_b_n;
        logic card_ready_busy_n;
        logic battery_warn_n;
        logic battery_status_change_n;
    } csic_pins_type;

    // isa style interrupt lines
    typedef struct packed {
        logic irq10;
        logic irq9;
        logic irq7;
        logic irq5;
        logic irq4;
        logic irq3;
    } csic_isa_type;
endpackage

/* File: src/csic_route.sv */
// routing decoder: steers one interrupt level to an isa line or the pci line
`timescale 1ns/1ns
`default_nettype none
module csic_route
    import csic_pkg::*;
(
    // control
    input  wire logic         [3:0] route,
    input  wire logic               irq_level,
    // steered outputs
    output csic_isa_type            isa_irq,
    output logic                    pci_irq
);
    // decode routing code; zero and reserved codes fall to pci
    always_comb begin
        isa_irq = '0;
        pci_irq = 1'b0;
        case (route)
            CSIC_ROUTE_IRQ3:  isa_irq.irq3  = irq_level;
            CSIC_ROUTE_IRQ4:  isa_irq.irq4  = irq_level;
            CSIC_ROUTE_IRQ5:  isa_irq.irq5  = irq_level;
            CSIC_ROUTE_IRQ7:  isa_irq.irq7  = irq_level;
            CSIC_ROUTE_IRQ9:  isa_irq.irq9  = irq_level;
            CSIC_ROUTE_IRQ10: isa_irq.irq10 = irq_level;
            default:          pci_irq       = irq_level;
        endcase
    end
endmodule
`default_nettype wire

/* File: src/csic_top.sv */
// card status change interrupt configuration with apb registers
`timescale 1ns/1ns
`default_nettype none
module csic_top
    import csic_pkg::*;
(
    // clock and reset
    input  wire logic               clk_sys,
    input  wire logic               rst_b,
    // apb slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic         [7:0] paddr,
    input  wire logic        [31:0] pwdata,
    output logic             [31:0] prdata,
    output logic                    pready,
    output logic                    pslverr,
    // card pins
    input  wire csic_pins_type      card_pins,
    // interrupt outputs
    output logic                    irq_out,
    output csic_isa_type            isa_irq,
    output logic                    pci_irq
);
    // register state
    logic                 [7:0] cfg_reg;
    logic                 [7:0] cfg_next;
    logic                 [3:0] stat_reg;
    logic                 [3:0] stat_next;
    logic                 [3:0] mask_reg;
    logic                 [3:0] mask_next;
    logic                 [1:0] ctrl_reg;
    logic                 [1:0] ctrl_next;
    logic                [31:0] prdata_reg;
    logic                [31:0] prdata_next;
    logic                       pslverr_reg;
    logic                       pslverr_next;
    // pin history for edge detection
    csic_pins_type              pins_reg;
    logic                       pins_valid_reg;
    // per event decode
    logic                 [3:0] event_hit;
    logic                 [3:0] event_en;
    logic                 [3:0] clr_mask;
    logic                       wr_access;
    logic                       rd_access;
    logic                       addr_ok;
    logic                       io_mode;
    logic                       card_removed;
    logic                       removed_reg;
    logic                       removal_edge;
    logic                       batt_dead;

    // apb phases; read data and error fetched at setup so they stand in the access cycle
    assign wr_access = psel & penable & pwrite;
    assign rd_access = psel & ~penable & ~pwrite;
    assign pready    = 1'b1;
    assign prdata    = prdata_reg;
    assign pslverr   = pslverr_reg;
    assign io_mode   = ctrl_reg[CSIC_IOMODE_BIT];

    // address decode
    always_comb begin
        case (paddr)
            CSIC_CFG_ADDR,
            CSIC_STAT_ADDR,
            CSIC_MASK_ADDR,
            CSIC_CTRL_ADDR,
            CSIC_PINS_ADDR: addr_ok = 1'b1;
            default:        addr_ok = 1'b0;
        endcase
    end

    // card removal: both detect pins high
    assign card_removed = card_pins.card_detect_a_n & card_pins.card_detect_b_n;
    assign removal_edge = card_removed & ~removed_reg & pins_valid_reg;
    // battery dead shows as both voltage detects low in memory mode
    assign batt_dead = ~card_pins.battery_status_change_n & ~card_pins.battery_warn_n;

    // raw events from the card pins; ready and warn gated by mode, dead source chosen by mode, detect ungated
    always_comb begin
        event_hit = 4'h0;
        if (pins_valid_reg) begin
            event_hit[CSIC_DET_BIT] = (card_pins.card_detect_a_n != pins_reg.card_detect_a_n) |
                                      (card_pins.card_detect_b_n != pins_reg.card_detect_b_n);
            event_hit[CSIC_RDY_BIT] = ~io_mode & card_pins.card_ready_busy_n &
                                      ~pins_reg.card_ready_busy_n;
            event_hit[CSIC_WARN_BIT] = ~io_mode & ~card_pins.battery_warn_n &
                                       pins_reg.battery_warn_n;
            if (io_mode) begin
                event_hit[CSIC_DEAD_BIT] = ~card_pins.battery_status_change_n;
            end else begin
                event_hit[CSIC_DEAD_BIT] = batt_dead;
            end
        end
    end

    // enables taken from the configuration register
    assign event_en = cfg_reg[3:0];

    // write one to clear mask for the status register
    assign clr_mask = (wr_access && paddr == CSIC_STAT_ADDR) ? pwdata[3:0] : 4'h0;

    // next register values
    always_comb begin
        cfg_next     = cfg_reg;
        mask_next    = mask_reg;
        ctrl_next    = ctrl_reg;
        prdata_next  = prdata_reg;
        pslverr_next = 1'b0;
        if (wr_access) begin
            case (paddr)
                CSIC_CFG_ADDR:  cfg_next  = pwdata[7:0];
                CSIC_MASK_ADDR: mask_next = pwdata[3:0];
                CSIC_CTRL_ADDR: ctrl_next = pwdata[1:0];
                default:        ;
            endcase
        end
        // error flag decided in setup, stands through the access cycle
        if (psel && !penable) begin
            pslverr_next = ~addr_ok;
        end
        if (rd_access) begin
            case (paddr)
                CSIC_CFG_ADDR:  prdata_next = {24'h000000, cfg_reg};
                CSIC_STAT_ADDR: prdata_next = {28'h0000000, stat_reg};
                CSIC_MASK_ADDR: prdata_next = {28'h0000000, mask_reg};
                CSIC_CTRL_ADDR: prdata_next = {30'h00000000, ctrl_reg};
                CSIC_PINS_ADDR: prdata_next = {27'h0000000, card_pins};
                default:        prdata_next = 32'h00000000;
            endcase
        end
        // removal reset clears routing, wins over a write
        if (ctrl_reg[CSIC_RRST_BIT] && removal_edge) begin
            cfg_next[7:CSIC_ROUTE_LSB] = 4'h0;
        end
        // set beats clear in the same cycle
        stat_next = (stat_reg & ~clr_mask) | (event_hit & event_en);
    end

    // register update
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cfg_reg        <= CSIC_CFG_RST;
            stat_reg       <= CSIC_STAT_RST;
            mask_reg       <= CSIC_MASK_RST;
            ctrl_reg       <= CSIC_CTRL_RST;
            prdata_reg     <= 32'h00000000;
            pslverr_reg    <= 1'b0;
            pins_reg       <= '0;
            pins_valid_reg <= 1'b0;
            removed_reg    <= 1'b0;
        end else begin
            cfg_reg        <= cfg_next;
            stat_reg       <= stat_next;
            mask_reg       <= mask_next;
            ctrl_reg       <= ctrl_next;
            prdata_reg     <= prdata_next;
            pslverr_reg    <= pslverr_next;
            pins_reg       <= card_pins;
            pins_valid_reg <= 1'b1;
            removed_reg    <= card_removed;
        end
    end

    // one level interrupt, high while an unmasked flag is set
    assign irq_out = |(stat_reg & mask_reg);

    // steering of the interrupt level
    csic_route u_route (
        .route     (cfg_reg[7:CSIC_ROUTE_LSB]),
        .irq_level (irq_out),
        .isa_irq   (isa_irq),
        .pci_irq   (pci_irq)
    );
endmodule
`default_nettype wire

/* File: dv/csic_card_model.sv */
// card side model: drives the socket status pins
`timescale 1ns/1ns
`default_nettype none
module csic_card_model
    import csic_pkg::*;
(
    // requested levels {present, ready, warn_n, status_n}
    input  wire logic [3:0] level,
    // socket pins
    output csic_pins_type   card_pins
);
    // both detect pins low while a card sits in the socket
    assign card_pins = {~level[3], ~level[3], level[2:0]};
endmodule
`default_nettype wire

/* File: dv/csic_top_assertions.sv */
// port checker for the card status irq block
`timescale 1ns/1ns
`default_nettype none
module csic_top_assertions
    import csic_pkg::*;
(
    // clock, reset and apb
    input wire logic          clk_sys,
    input wire logic          rst_b,
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pwrite,
    input wire logic [7:0]    paddr,
    input wire logic [31:0]   pwdata,
    input wire logic          pready,
    input wire logic          pslverr,
    // pins and interrupts
    input wire csic_pins_type card_pins,
    input wire logic          irq_out,
    input wire csic_isa_type  isa_irq,
    input wire logic          pci_irq
);
    logic [7:0] cfg_reg;
    logic [3:0] mask_reg;
    logic [1:0] ctrl_reg;
    logic [5:0] isa_exp;
    logic       wr;
    logic       removed;
    logic       removed_reg;
    // shadow of software writes and of the removal reset of the route field
    assign wr = psel && penable && pwrite && pready;
    assign removed = card_pins.card_detect_a_n && card_pins.card_detect_b_n;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cfg_reg <= 8'h00;
            mask_reg <= 4'h0;
            ctrl_reg <= 2'h0;
            removed_reg <= 1'b1; // no removal edge on the first cycle after reset
        end else begin
            removed_reg <= removed;
            if (wr && paddr == CSIC_CFG_ADDR) begin
                cfg_reg <= pwdata[7:0];
            end
            if (wr && paddr == CSIC_MASK_ADDR) begin
                mask_reg <= pwdata[3:0];
            end
            if (wr && paddr == CSIC_CTRL_ADDR) begin
                ctrl_reg <= pwdata[1:0];
            end
            // removal beats a write to the route bits
            if (ctrl_reg[1] && removed && !removed_reg) begin
                cfg_reg[7:4] <= 4'h0;
            end
        end
    end
    // expected isa line from the route code
    assign isa_exp = {cfg_reg[7:4] == 4'hA, cfg_reg[7:4] == 4'h9, cfg_reg[7:4] == 4'h7,
                      cfg_reg[7:4] == 4'h5, cfg_reg[7:4] == 4'h4, cfg_reg[7:4] == 4'h3};
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // event seen, then interrupt
    sequence irq_soon;
        ##[1:6] irq_out;
    endsequence
    sequence det_seen;
        cfg_reg[3] && mask_reg[3] && $changed({card_pins.card_detect_a_n, card_pins.card_detect_b_n});
    endsequence
    sequence rdy_seen;
        cfg_reg[2] && mask_reg[2] && !ctrl_reg[0] && $rose(card_pins.card_ready_busy_n);
    endsequence
    a_irq_quiet: assert property (!irq_out |-> !pci_irq && isa_irq == 6'h00) else $error("steered line high");
    a_isa_route: assert property (irq_out && $stable(cfg_reg) |-> isa_irq == isa_exp) else $error("isa line");
    a_pci_route: assert property (irq_out && $stable(cfg_reg) |-> pci_irq == (isa_exp == 6'h00))
        else $error("pci line");
    a_det_irq: assert property (det_seen |-> irq_soon) else $error("detect irq missing");
    a_rdy_irq: assert property (rdy_seen |-> irq_soon) else $error("ready irq missing");
    a_stat_irq: assert property (cfg_reg[0] && mask_reg[0] && ctrl_reg[0] && !card_pins.battery_status_change_n
        |-> irq_soon) else $error("status irq missing");
    a_bad_addr: assert property (psel && penable && paddr > CSIC_PINS_ADDR |-> pslverr) else $error("no slverr");
    a_reset_quiet: assert property ($rose(rst_b) |-> !irq_out && !pci_irq) else $error("irq after reset");
endmodule
bind csic_top csic_top_assertions u_chk (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .card_pins(card_pins), .irq_out(irq_out), .isa_irq(isa_irq), .pci_irq(pci_irq));
`default_nettype wire

/* File: dv/csic_top_bench.sv */
// self-checking bench for the card status irq block
`timescale 1ns/1ns
`default_nettype none
module csic_top_bench import csic_pkg::*;;
    logic          clk_sys = 1'b0;
    logic          rst_b = 1'b0;
    logic          psel = 1'b0;
    logic          penable = 1'b0;
    logic          pwrite = 1'b0;
    logic [7:0]    paddr = 8'h00;
    logic [31:0]   pwdata = 32'h0000_0000;
    logic [31:0]   prdata, rd;
    logic          pready, pslverr, irq_out, pci_irq, err;
    logic [3:0]    level = 4'h7;
    csic_pins_type card_pins;
    csic_isa_type  isa_irq;
    int            num_errors = 0;
    int            total_checks = 0;
    // {code, isa lines, pci}
    logic [10:0]   route_rows [12] = '{11'h001, 11'h081, 11'h101, 11'h182, 11'h204, 11'h288,
                                       11'h301, 11'h390, 11'h401, 11'h4A0, 11'h540, 11'h781};
    // {cfg, ctrl, levels before, levels after, status}
    logic [23:0]   ev_rows [9] = '{24'h0807F8, 24'h0707F0, 24'h040BF4,
                                   24'h041BF0, 24'h020FD2, 24'h021FD0,
                                   24'h010FC1, 24'h011FE1, 24'h001FE0};
    always #5 clk_sys = ~clk_sys;
    csic_top DUT (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .card_pins(card_pins), .irq_out(irq_out), .isa_irq(isa_irq), .pci_irq(pci_irq));
    csic_card_model u_card (.level(level), .card_pins(card_pins));
    // verdict and end of run
    task automatic conclude();
        $display("errors %0d checks %0d", num_errors, total_checks);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer; read data and error taken at the edge with pready high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            num_errors++;
            conclude();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    initial begin
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        // detect event pending, then all six isa route codes and the codes 0, 1, 2, 6, 8 and F that fall to pci
        apb(1'b1, CSIC_MASK_ADDR, 32'h0000_000F);
        apb(1'b1, CSIC_CFG_ADDR, 32'h0000_0008);
        level <= 4'hF;
        repeat (6) @(posedge clk_sys);
        chk(irq_out, 1'b1);
        foreach (route_rows[i]) begin
            apb(1'b1, CSIC_CFG_ADDR, {24'h0, route_rows[i][10:7], 4'h8});
            chk({isa_irq, pci_irq}, route_rows[i][6:0]);
        end
        // event sources per mode
        foreach (ev_rows[i]) begin
            level <= ev_rows[i][11:8];
            repeat (6) @(posedge clk_sys);
            apb(1'b1, CSIC_CFG_ADDR, {24'h0, ev_rows[i][23:16]});
            apb(1'b1, CSIC_CTRL_ADDR, {28'h0, ev_rows[i][15:12]});
            apb(1'b1, CSIC_STAT_ADDR, 32'h0000_000F);
            level <= ev_rows[i][7:4];
            repeat (6) @(posedge clk_sys);
            apb(1'b0, CSIC_STAT_ADDR, 32'h0);
            chk(rd, {28'h0, ev_rows[i][3:0]});
        end
        // removal clears route, masked irq, write one to clear
        apb(1'b1, CSIC_MASK_ADDR, 32'h0);
        apb(1'b1, CSIC_CTRL_ADDR, 32'h0000_0002);
        apb(1'b1, CSIC_CFG_ADDR, 32'h0000_0038);
        level <= 4'h7;
        repeat (6) @(posedge clk_sys);
        apb(1'b0, CSIC_CFG_ADDR, 32'h0);
        chk(rd, 32'h0000_0008);
        chk(irq_out, 1'b0);
        apb(1'b1, CSIC_STAT_ADDR, 32'h0000_0008);
        apb(1'b0, CSIC_STAT_ADDR, 32'h0);
        chk(rd, 32'h0);
        // unmapped read
        apb(1'b0, 8'h20, 32'h0);
        chk(err, 1'b1);
        chk(rd, 32'h0);
        // reset in mid run
        rst_b <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        apb(1'b0, CSIC_CFG_ADDR, 32'h0);
        chk(rd, 32'h0);
        conclude();
    end
endmodule
`default_nettype wire
